// ===== hw/ptc_periodic_tick_counter.sv
// Periodic tick counter: source select, prescaler, 8-bit modulo counter and match interrupt.
// Assumes all source clocks are far slower than the 100 MHz register clock; they are
// sampled as data, so each source must stay high and low for at least two clock periods.
//
// The implementer's own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "ptc_regs.svh"

// Operation
// - Counter advances per prescaler period, wraps at limit
// - Flag sets on step from limit to zero
// - Limit zero sets flag every prescaler tick
// - Bit 7 flag; write one clears flag
// - Bit 4 enables interrupt while flag set
// - Bits 6:5 pick the prescaler source
// - Changed source select clears prescaler and counter
// - Changed prescale select clears prescaler and counter
// - Any limit write clears prescaler and counter
// - Count register reads count, ignores writes
// - Prescale code zero stops counting
// - Low source bit zero divider table
// - Low source bit one divider table
// - Reset: stopped, zero, oscillator source, flags clear
// - Counting and interrupt continue in wait
// - Deep stop keeps only oscillator source running
// - Debug freezes counting, resumes from held value
module ptc_periodic_tick_counter (
  input wire logic clock,
  input wire logic reset,
  input wire ptc_pkg::ptc_bus_s bus_req,
  output var ptc_pkg::ptc_byte_t bus_rdata,
  input wire logic low_power_osc_clock,
  input wire logic external_ref_clock,
  input wire logic internal_ref_clock,
  input wire logic debug_active,
  input wire logic stop_deep,
  output logic irq
);
  import ptc_pkg::*;

  ptc_ctrl_s ctrl;
  ptc_byte_t tick_count;
  ptc_byte_t tick_match_limit;
  ptc_byte_t event_status;
  ptc_byte_t event_mask;
  ptc_pre_t pre_count;
  logic [`PTC_SYNC_LEN-1:0] sync [`PTC_SRC_NUM];
  logic [`PTC_SRC_NUM-1:0] src_level;
  logic [`PTC_SRC_NUM-1:0] src_rise;
  logic [`PTC_SRC_NUM-1:0] src_raw;
  ptc_ctrl_s wr_ctrl;
  ptc_pre_t divisor;
  ptc_src_e src_onehot;
  logic wr_sc;
  logic wr_limit;
  logic restart;
  logic src_ok;
  logic running;
  logic src_edge;
  logic tick;
  logic wrap;

  // Divide ratio for a prescale code; the low source bit picks the table row.
  function automatic ptc_pre_t div_of(input logic row, input logic [3:0] ps);
    ptc_pre_t d;
    d = `PTC_PRE_ONE;
    case ({row, ps})
      5'h01: d = 18'h00008;
      5'h02: d = 18'h00020;
      5'h03: d = 18'h00040;
      5'h04: d = 18'h00080;
      5'h05: d = 18'h00100;
      5'h06: d = 18'h00200;
      5'h07: d = 18'h00400;
      5'h08: d = 18'h00001;
      5'h09: d = 18'h00002;
      5'h0a: d = 18'h00004;
      5'h0b: d = 18'h0000a;
      5'h0c: d = 18'h00010;
      5'h0d: d = 18'h00064;
      5'h0e: d = 18'h001f4;
      5'h0f: d = 18'h003e8;
      5'h11: d = 18'h00400;
      5'h12: d = 18'h00800;
      5'h13: d = 18'h01000;
      5'h14: d = 18'h02000;
      5'h15: d = 18'h04000;
      5'h16: d = 18'h08000;
      5'h17: d = 18'h10000;
      5'h18: d = 18'h003e8;
      5'h19: d = 18'h007d0;
      5'h1a: d = 18'h01388;
      5'h1b: d = 18'h02710;
      5'h1c: d = 18'h04e20;
      5'h1d: d = 18'h0c350;
      5'h1e: d = 18'h186a0;
      5'h1f: d = 18'h30d40;
      default: d = `PTC_PRE_ONE;
    endcase
    return d;
  endfunction : div_of

  assign src_raw = {internal_ref_clock, external_ref_clock, low_power_osc_clock};

  // Each source is sampled by three flops; a level counts only once the last two agree,
  // so the first flop feeds nothing but the second.
  // source edge crossing
  genvar gi;
  generate
    for (gi = 0; gi < `PTC_SRC_NUM; gi++) begin : g_sync
      always_ff @(posedge clock) begin
        if (reset) begin
          sync[gi] <= '0;
          src_level[gi] <= 1'b0;
        end else begin
          sync[gi] <= {sync[gi][`PTC_SYNC_LEN-2:0], src_raw[gi]};
          if (sync[gi][1] == sync[gi][2]) begin
            src_level[gi] <= sync[gi][2];
          end
        end
      end
      assign src_rise[gi] = (sync[gi][1] == sync[gi][2]) && sync[gi][2] && !src_level[gi];
    end
  endgenerate

  always_comb begin
    case (ctrl.source_select)
      2'h0: src_onehot = PTC_CLK_LPO;
      2'h1: src_onehot = PTC_CLK_EXT;
      default: src_onehot = PTC_CLK_INT;
    endcase
  end
  assign src_edge = |(src_rise & src_onehot);

  assign src_ok = (ctrl.source_select == `PTC_SRC_LPO) || !stop_deep;

  // Wait mode needs no input: counting and the interrupt simply keep going.
  // wait keeps running
  assign running = (ctrl.prescale_select != `PTC_PS_OFF) && !debug_active && src_ok;

  assign divisor = div_of(ctrl.source_select[0], ctrl.prescale_select);

  assign wr_sc = bus_req.wr && (bus_req.addr == `PTC_OFF_STATUS_CONTROL);
  assign wr_limit = bus_req.wr && (bus_req.addr == `PTC_OFF_MATCH_LIMIT);
  assign wr_ctrl = ptc_ctrl_s'(bus_req.wdata);

  assign restart = wr_limit ||
                   (wr_sc && (wr_ctrl.source_select != ctrl.source_select)) ||
                   (wr_sc && (wr_ctrl.prescale_select != ctrl.prescale_select));

  assign tick = running && src_edge && (pre_count == divisor - `PTC_PRE_ONE);
  assign wrap = tick && (tick_count == tick_match_limit);

  always_ff @(posedge clock) begin
    if (reset) begin
      ctrl.source_select <= `PTC_SRC_LPO;
      ctrl.match_irq_enable <= 1'b0;
      ctrl.prescale_select <= `PTC_PS_OFF;
    end else if (wr_sc) begin
      ctrl.source_select <= wr_ctrl.source_select;
      ctrl.match_irq_enable <= wr_ctrl.match_irq_enable;
      ctrl.prescale_select <= wr_ctrl.prescale_select;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      tick_match_limit <= `PTC_RST_BYTE;
    end else if (wr_limit) begin
      tick_match_limit <= bus_req.wdata;
    end
  end

  // The prescaler holds its value while not running, so a debug freeze resumes in place.
  always_ff @(posedge clock) begin
    if (reset || restart) begin
      pre_count <= `PTC_RST_PRE;
    end else if (running && src_edge) begin
      pre_count <= tick ? `PTC_RST_PRE : pre_count + `PTC_PRE_ONE;
    end
  end

  always_ff @(posedge clock) begin
    if (reset || restart) begin
      tick_count <= `PTC_RST_BYTE;
    end else if (tick) begin
      tick_count <= wrap ? `PTC_RST_BYTE : tick_count + `PTC_CNT_ONE;
    end
  end

  // A wrap in the clearing cycle wins, so no match is lost.
  // flag on wrap
  always_ff @(posedge clock) begin
    if (reset) begin
      ctrl.match_flag <= 1'b0;
    end else if (wrap) begin
      ctrl.match_flag <= 1'b1;
    end else if (wr_sc && bus_req.wdata[`PTC_SC_FLAG_BIT]) begin
      ctrl.match_flag <= 1'b0;
    end
  end

  // Sticky event copy for polling code; a read clears it, a new event wins.
  always_ff @(posedge clock) begin
    if (reset) begin
      event_status <= `PTC_RST_BYTE;
    end else if (wrap) begin
      event_status[`PTC_EVT_MATCH_BIT] <= 1'b1;
    end else if (bus_req.rd && (bus_req.addr == `PTC_OFF_EVENT_STATUS)) begin
      event_status <= `PTC_RST_BYTE;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      event_mask <= `PTC_RST_BYTE;
    end else if (bus_req.wr && (bus_req.addr == `PTC_OFF_EVENT_MASK)) begin
      event_mask <= bus_req.wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= (ctrl.match_flag && ctrl.match_irq_enable) || (|(event_status & event_mask));
    end
  end

  always_ff @(posedge clock) begin
    if (reset || !bus_req.rd) begin
      bus_rdata <= `PTC_RST_BYTE;
    end else begin
      case (bus_req.addr)
        `PTC_OFF_STATUS_CONTROL: bus_rdata <= ctrl;
        `PTC_OFF_COUNT: bus_rdata <= tick_count;
        `PTC_OFF_MATCH_LIMIT: bus_rdata <= tick_match_limit;
        `PTC_OFF_EVENT_STATUS: bus_rdata <= event_status;
        `PTC_OFF_EVENT_MASK: bus_rdata <= event_mask;
        default: bus_rdata <= `PTC_RST_BYTE;
      endcase
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);

  property p_count_step;
    tick && !restart && (tick_count != tick_match_limit) |=>
      tick_count == $past(tick_count) + `PTC_CNT_ONE;
  endproperty
  a_count_step: assert property (p_count_step) else $error("count did not step");

  property p_flag_cause;
    $rose(ctrl.match_flag) |-> $past(wrap);
  endproperty
  a_flag_cause: assert property (p_flag_cause) else $error("flag rose without wrap");

  property p_zero_limit;
    tick && (tick_match_limit == `PTC_RST_BYTE) |=> ctrl.match_flag && (tick_count == `PTC_RST_BYTE);
  endproperty
  a_zero_limit: assert property (p_zero_limit) else $error("zero limit missed flag");

  property p_flag_clear;
    wr_sc && bus_req.wdata[`PTC_SC_FLAG_BIT] && !wrap |=> !ctrl.match_flag;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");

  property p_irq_follows;
    ctrl.match_flag && ctrl.match_irq_enable |=> irq;
  endproperty
  a_irq_follows: assert property (p_irq_follows) else $error("interrupt missing");

  property p_restart;
    restart |=> (tick_count == `PTC_RST_BYTE) && (pre_count == `PTC_RST_PRE);
  endproperty
  a_restart: assert property (p_restart) else $error("restart did not clear");

  property p_count_hold;
    !tick && !restart |=> $stable(tick_count);
  endproperty
  a_count_hold: assert property (p_count_hold) else $error("count moved by itself");

  property p_off_halts;
    (ctrl.prescale_select == `PTC_PS_OFF) |-> !tick;
  endproperty
  a_off_halts: assert property (p_off_halts) else $error("ticked while off");

  property p_deep_stop;
    stop_deep && (ctrl.source_select != `PTC_SRC_LPO) |=> $stable(pre_count) || $past(restart);
  endproperty
  a_deep_stop: assert property (p_deep_stop) else $error("counted in deep stop");

  property p_debug_freeze;
    debug_active && !restart ##1 debug_active |-> $stable(tick_count) && $stable(pre_count);
  endproperty
  a_debug_freeze: assert property (p_debug_freeze) else $error("counted in debug");

  c_wrap: cover property (wrap ##1 ctrl.match_flag);
  c_irq: cover property ($rose(irq));
  c_restart: cover property (tick ##[1:100] restart);
  c_debug: cover property (debug_active ##1 !debug_active ##[1:50] tick);

endmodule : ptc_periodic_tick_counter
`default_nettype wire

// ===== hw/ptc_regs.svh
// Register offsets, field positions and reset values of the periodic tick counter.
// Assumes a byte-wide register port with a three-bit word address.
`ifndef PTC_REGS_SVH
`define PTC_REGS_SVH

`define PTC_ADDR_W 3
`define PTC_DATA_W 8
`define PTC_PRE_W 18

`define PTC_OFF_STATUS_CONTROL 3'h0
`define PTC_OFF_COUNT 3'h1
`define PTC_OFF_MATCH_LIMIT 3'h2
`define PTC_OFF_EVENT_STATUS 3'h3
`define PTC_OFF_EVENT_MASK 3'h4

`define PTC_SC_FLAG_BIT 7
`define PTC_EVT_MATCH_BIT 0

`define PTC_RST_BYTE 8'h00
`define PTC_RST_PRE 18'h00000
`define PTC_PRE_ONE 18'h00001
`define PTC_CNT_ONE 8'h01
`define PTC_PS_OFF 4'h0
`define PTC_SRC_LPO 2'h0
`define PTC_SRC_NUM 3
`define PTC_SYNC_LEN 3

`endif

// ===== hw/ptc_pkg.sv
// Types shared by the periodic tick counter: register request carrier and control layout.
// Assumes ptc_regs.svh is on the include path.
`include "ptc_regs.svh"

package ptc_pkg;

  typedef logic [`PTC_ADDR_W-1:0] ptc_addr_t;
  typedef logic [`PTC_DATA_W-1:0] ptc_byte_t;
  typedef logic [`PTC_PRE_W-1:0] ptc_pre_t;

  // One register request; rd and wr are never high together.
  typedef struct packed {
    logic rd;
    logic wr;
    ptc_addr_t addr;
    ptc_byte_t wdata;
  } ptc_bus_s;

  // Field order equals the status/control byte layout, bit 7 down to bit 0.
  typedef struct packed {
    logic match_flag;
    logic [1:0] source_select;
    logic match_irq_enable;
    logic [3:0] prescale_select;
  } ptc_ctrl_s;

  typedef enum logic [2:0] {
    PTC_CLK_LPO = 3'h1,
    PTC_CLK_EXT = 3'h2,
    PTC_CLK_INT = 3'h4
  } ptc_src_e;

endpackage : ptc_pkg

// ===== tb/tb_ptc_periodic_tick_counter.sv
// Self-checking bench for the periodic tick counter: register port, sources and interrupt.
// Assumes the package and register header are compiled first; sources are toggled slowly.
`timescale 1ns/1ps
`default_nettype none
`include "ptc_regs.svh"
module tb_ptc_periodic_tick_counter;
  import ptc_pkg::*;
  logic clock, reset, debug_active, stop_deep, irq;
  logic [2:0] src;
  ptc_bus_s bus_req;
  ptc_byte_t bus_rdata;
  int n_fail, compares;
  int rows[4] = '{0, 0, 0, 1};
  int codes[4] = '{1, 9, 11, 8};

  ptc_periodic_tick_counter uut (.clock(clock), .reset(reset), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .low_power_osc_clock(src[0]), .external_ref_clock(src[1]),
    .internal_ref_clock(src[2]), .debug_active(debug_active), .stop_deep(stop_deep),
    .irq(irq));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(ptc_addr_t a, ptc_byte_t d);
    @(posedge clock);
    bus_req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge clock);
    bus_req <= '0;
  endtask : wr

  // Read data stand only in the cycle after the strobe, so they are sampled just after it.
  task automatic rd(ptc_addr_t a, ptc_byte_t exp, string what);
    @(posedge clock);
    bus_req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(posedge clock);
    bus_req <= '0;
    #1 chk(what, exp, bus_rdata);
  endtask : rd

  // Each level is held at least four clocks, above the three-flop sampler's minimum.
  task automatic pulse(int s, int n);
    repeat (n) begin
      @(posedge clock);
      src[s] <= 1'b1;
      repeat (4) @(posedge clock);
      src[s] <= 1'b0;
      repeat (4) @(posedge clock);
    end
  endtask : pulse

  task automatic chk_irq(logic exp);
    repeat (2) @(posedge clock);
    #1 chk("irq", {7'h00, exp}, {7'h00, irq});
  endtask : chk_irq

  function automatic int div(int row, int code);
    int t0[16] = '{0, 8, 32, 64, 128, 256, 512, 1024, 1, 2, 4, 10, 16, 100, 500, 1000};
    int t1[16] = '{0, 1024, 2048, 4096, 8192, 16384, 32768, 65536,
      1000, 2000, 5000, 10000, 20000, 50000, 100000, 200000};
    return (row != 0) ? t1[code] : t0[code];
  endfunction : div

  task automatic close_out();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : close_out

  initial begin
    repeat (40000) @(posedge clock);
    n_fail++;
    $display("unexpected timeout: expected end of tests, seen none");
    close_out();
  end

  initial begin
    int lim;
    ptc_byte_t sc;
    reset = 1'b1;
    debug_active = 1'b0;
    stop_deep = 1'b0;
    src = 3'h0;
    bus_req = '0;
    n_fail = 0;
    compares = 0;
    void'($urandom(85810));
    repeat (4) @(posedge clock);
    reset <= 1'b0;
    for (int a = 0; a < 8; a++) begin
      rd(a[2:0], 8'h00, "reset value");
    end
    chk_irq(1'b0);
    pulse(0, 3);
    rd(`PTC_OFF_COUNT, 8'h00, "count while off");
    $display("test reset done");
    lim = 2 + ($urandom % 14);
    wr(`PTC_OFF_MATCH_LIMIT, lim[7:0]);
    wr(`PTC_OFF_STATUS_CONTROL, 8'h08);
    pulse(0, lim);
    rd(`PTC_OFF_COUNT, lim[7:0], "count at limit");
    rd(`PTC_OFF_STATUS_CONTROL, 8'h08, "flag at limit");
    pulse(0, 1);
    rd(`PTC_OFF_COUNT, 8'h00, "count after wrap");
    rd(`PTC_OFF_STATUS_CONTROL, 8'h88, "flag after wrap");
    chk_irq(1'b0);
    wr(`PTC_OFF_STATUS_CONTROL, 8'h18);
    chk_irq(1'b1);
    rd(`PTC_OFF_STATUS_CONTROL, 8'h98, "flag after zero write");
    wr(`PTC_OFF_STATUS_CONTROL, 8'h98);
    rd(`PTC_OFF_STATUS_CONTROL, 8'h18, "flag after one write");
    chk_irq(1'b0);
    rd(`PTC_OFF_EVENT_STATUS, 8'h01, "event status");
    rd(`PTC_OFF_EVENT_STATUS, 8'h00, "event status after read");
    wr(`PTC_OFF_EVENT_MASK, 8'h01);
    wr(`PTC_OFF_STATUS_CONTROL, 8'h88);
    pulse(0, lim + 1);
    chk_irq(1'b1);
    rd(`PTC_OFF_EVENT_STATUS, 8'h01, "masked event");
    chk_irq(1'b0);
    $display("test wrap and interrupt done");
    pulse(0, 1);
    wr(`PTC_OFF_COUNT, 8'h5a);
    rd(`PTC_OFF_COUNT, 8'h01, "count after write");
    wr(`PTC_OFF_MATCH_LIMIT, lim[7:0]);
    rd(`PTC_OFF_COUNT, 8'h00, "count after limit write");
    pulse(0, 1);
    wr(`PTC_OFF_STATUS_CONTROL, 8'h09);
    rd(`PTC_OFF_COUNT, 8'h00, "count after prescale change");
    wr(`PTC_OFF_STATUS_CONTROL, 8'h29);
    rd(`PTC_OFF_COUNT, 8'h00, "count after source change");
    pulse(1, 2);
    pulse(0, 2);
    // Row one divides by 2000 here, so two edges on each source leave the count at zero.
    rd(`PTC_OFF_COUNT, 8'h00, "external source count");
    wr(`PTC_OFF_STATUS_CONTROL, 8'h49);
    pulse(2, 2);
    rd(`PTC_OFF_COUNT, 8'h01, "internal source count");
    @(posedge clock);
    stop_deep <= 1'b1;
    pulse(2, 2);
    rd(`PTC_OFF_COUNT, 8'h01, "internal source in deep stop");
    wr(`PTC_OFF_STATUS_CONTROL, 8'h09);
    pulse(0, 2);
    rd(`PTC_OFF_COUNT, 8'h01, "oscillator in deep stop");
    @(posedge clock);
    stop_deep <= 1'b0;
    debug_active <= 1'b1;
    pulse(0, 4);
    rd(`PTC_OFF_COUNT, 8'h01, "count in debug");
    @(posedge clock);
    debug_active <= 1'b0;
    pulse(0, 2);
    rd(`PTC_OFF_COUNT, 8'h02, "count after debug");
    $display("test restart and modes done");
    wr(`PTC_OFF_MATCH_LIMIT, 8'h00);
    wr(`PTC_OFF_STATUS_CONTROL, 8'h88);
    repeat (3) begin
      pulse(0, 1);
      rd(`PTC_OFF_STATUS_CONTROL, 8'h88, "flag with zero limit");
      wr(`PTC_OFF_STATUS_CONTROL, 8'h88);
    end
    rd(`PTC_OFF_STATUS_CONTROL, 8'h08, "flag cleared");
    $display("test zero limit done");
    foreach (codes[i]) begin
      sc = {2'h0, rows[i][0], 1'b0, codes[i][3:0]};
      wr(`PTC_OFF_STATUS_CONTROL, sc);
      wr(`PTC_OFF_MATCH_LIMIT, 8'hff);
      pulse(rows[i], div(rows[i], codes[i]) - 1);
      rd(`PTC_OFF_COUNT, 8'h00, "count before divide");
      pulse(rows[i], 1);
      rd(`PTC_OFF_COUNT, 8'h01, "count after divide");
    end
    $display("test divider table done");
    close_out();
  end
endmodule : tb_ptc_periodic_tick_counter
`default_nettype wire
